// *** hdl/tgo_defs.vh ***
// constants, register map and field layout of the timer gate and overflow block
`ifndef TGO_DEFS_VH
`define TGO_DEFS_VH

// register byte addresses
`define TGO_ADDR_TCTRL      8'h00
`define TGO_ADDR_GCTRL      8'h04
`define TGO_ADDR_COUNT      8'h08
`define TGO_ADDR_CAPCOMP    8'h0c
`define TGO_ADDR_CCCTRL     8'h10
`define TGO_ADDR_PFLAG      8'h14
`define TGO_ADDR_PEN        8'h18
`define TGO_ADDR_IRQCTL     8'h1c

// timer_control_reg fields
`define TGO_T_ON            0
`define TGO_T_SYNCDIS       1
`define TGO_T_CS_LO         2
`define TGO_T_CS_HI         3
`define TGO_T_OSCEN         4
`define TGO_CS_EXT          2'b10

// gate_control_reg fields
`define TGO_G_ARM           3
`define TGO_G_VAL           2
`define TGO_G_SPM           4
`define TGO_G_TM            5
`define TGO_G_POL           6
`define TGO_G_EN            7

// capture/compare control fields
`define TGO_CC_MODE_LO      0
`define TGO_CC_MODE_HI      1
`define TGO_CC_RISE         2
`define TGO_CC_OFF          2'b00
`define TGO_CC_CAPTURE      2'b01
`define TGO_CC_COMPARE      2'b10
`define TGO_CC_SPECIAL      2'b11

// flag / enable bit positions
`define TGO_F_OVF           0
`define TGO_F_GATE          1
`define TGO_F_CC            2
`define TGO_I_PERIPHERAL_IRQ_ENABLE          6
`define TGO_I_GIE           7

// values
`define TGO_CNT_MAX         16'hffff
`define TGO_CNT_ZERO        16'h0000
`define TGO_RESP_OKAY       2'b00
`define TGO_RESP_SLVERR     2'b10

`endif

// *** hdl/tgo_sync.v ***
// two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
module tgo_sync #(
    parameter WIDTH = 4
) (
    input  wire             aclk,
    input  wire             aresetn,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] stage1;
    reg [WIDTH-1:0] stage2;

    // one pair of flops per bit; stage1 feeds only stage2
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            always @(posedge aclk) begin
                if (!aresetn) begin
                    stage1[i] <= 1'b0;
                    stage2[i] <= 1'b0;
                end else begin
                    stage1[i] <= async_in[i];
                    stage2[i] <= stage1[i];
                end
            end
        end
    endgenerate

    assign sync_out = stage2;
endmodule

// *** hdl/tgo_timer.v ***
// timer/counter with gate control, overflow flags and capture/compare time base
//
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "tgo_defs.vh"
module tgo_timer (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        gate_pin,
    input  wire        ext_clk_pin,
    input  wire        capture_pin,
    input  wire        sleep_mode,
    output reg         irq,
    output reg         wake,
    output reg         timer_osc_run
);
    // pin synchronisers
    wire [3:0] pins_sync;
    wire       gate_in;
    wire       ext_in;
    wire       cap_in;
    wire       sleep_in;

    tgo_sync #(.WIDTH(4)) u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in ({sleep_mode, capture_pin, ext_clk_pin, gate_pin}),
        .sync_out (pins_sync)
    );
    assign gate_in  = pins_sync[0];
    assign ext_in   = pins_sync[1];
    assign cap_in   = pins_sync[2];
    assign sleep_in = pins_sync[3];

    // software registers
    reg [4:0]  timer_control_reg;
    reg [7:0]  gate_control_reg;
    reg [15:0] counter;
    reg [15:0] capcomp;
    reg [2:0]  capcomp_ctrl;
    reg [2:0]  peripheral_flag_reg;
    reg [2:0]  peripheral_enable_reg;
    reg [7:0]  irq_control_reg;

    // gate and edge state
    reg        toggle_ff;
    reg        gate_src_q;
    reg        gate_tog_q;
    reg        pulse_open;
    reg        gate_level_status;
    reg        ext_q;
    reg        cap_q;
    reg        match_q;

    // axi write channel holding
    reg        aw_held;
    reg        w_held;
    reg [7:0]  wr_addr;
    reg [31:0] wr_data;
    reg [3:0]  wr_strb;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    wire wr_go = aw_held && w_held && !s_axi_bvalid;
    wire rd_go = s_axi_arvalid && !s_axi_rvalid;

    // write strobes per register
    wire wr_tctrl  = wr_go && (wr_addr == `TGO_ADDR_TCTRL);
    wire wr_gctrl  = wr_go && (wr_addr == `TGO_ADDR_GCTRL);
    wire wr_cnt    = wr_go && (wr_addr == `TGO_ADDR_COUNT);
    wire wr_ccr    = wr_go && (wr_addr == `TGO_ADDR_CAPCOMP);
    wire wr_ccctl  = wr_go && (wr_addr == `TGO_ADDR_CCCTRL);
    wire wr_pflag  = wr_go && (wr_addr == `TGO_ADDR_PFLAG);
    wire wr_pen    = wr_go && (wr_addr == `TGO_ADDR_PEN);
    wire wr_irqc   = wr_go && (wr_addr == `TGO_ADDR_IRQCTL);
    wire wr_cnt_lo = wr_cnt && wr_strb[0];
    wire wr_cnt_hi = wr_cnt && wr_strb[1];
    wire wr_hit    = wr_tctrl | wr_gctrl | wr_cnt | wr_ccr | wr_ccctl
                   | wr_pflag | wr_pen | wr_irqc;

    // control field decode
    wire       counter_on        = timer_control_reg[`TGO_T_ON];
    wire       sync_disable      = timer_control_reg[`TGO_T_SYNCDIS];
    wire [1:0] clock_source_select =
        timer_control_reg[`TGO_T_CS_HI:`TGO_T_CS_LO];
    wire       timer_osc_enable  = timer_control_reg[`TGO_T_OSCEN];
    wire       gate_function_enable = gate_control_reg[`TGO_G_EN];
    wire       gate_polarity     = gate_control_reg[`TGO_G_POL];
    wire       gate_toggle_enable = gate_control_reg[`TGO_G_TM];
    wire       single_pulse_enable = gate_control_reg[`TGO_G_SPM];
    wire       gate_arm_flag     = gate_control_reg[`TGO_G_ARM];
    wire [1:0] cc_mode = capcomp_ctrl[`TGO_CC_MODE_HI:`TGO_CC_MODE_LO];
    wire       cc_rise = capcomp_ctrl[`TGO_CC_RISE];
    wire       global_irq_enable = irq_control_reg[`TGO_I_GIE];
    wire       peripheral_irq_enable = irq_control_reg[`TGO_I_PERIPHERAL_IRQ_ENABLE];

    // gate path: polarity, then toggle flip-flop, then single pulse window
    wire gate_src  = gate_in ~^ gate_polarity;
    wire gate_rise = gate_src && !gate_src_q;
    wire gate_tog  = gate_toggle_enable ? toggle_ff : gate_src;
    wire tog_rise  = gate_tog && !gate_tog_q;
    wire tog_fall  = !gate_tog && gate_tog_q;
    wire gate_value = single_pulse_enable ? (pulse_open && gate_tog) : gate_tog;
    // trailing edge of the armed pulse ends single pulse capture
    wire pulse_done = single_pulse_enable && gate_arm_flag
                    && pulse_open && tog_fall;
    wire gate_fall  = gate_level_status && !gate_value;

    // incrementing edge: instruction clock or external pin rising edge
    wire ext_rise = ext_in && !ext_q;
    wire ext_src  = (clock_source_select == `TGO_CS_EXT);
    wire sleep_ok = ext_src && sync_disable;
    wire tick_src = ext_src ? ext_rise : 1'b1;
    wire gate_ok  = !gate_function_enable || gate_value;
    wire cnt_tick = counter_on && tick_src && gate_ok && (!sleep_in || sleep_ok);
    wire rollover = cnt_tick && (counter == `TGO_CNT_MAX);

    // capture and compare events
    wire cap_edge  = cc_rise ? (cap_in && !cap_q) : (!cap_in && cap_q);
    wire do_cap    = (cc_mode == `TGO_CC_CAPTURE) && cap_edge;
    wire match     = (capcomp == counter);
    wire cmp_mode  = (cc_mode == `TGO_CC_COMPARE) || (cc_mode == `TGO_CC_SPECIAL);
    wire cmp_evt   = cmp_mode && match && !match_q;
    wire special   = (cc_mode == `TGO_CC_SPECIAL) && cmp_evt;

    // next counter value: write first, then special trigger, then count
    reg [15:0] next_counter;
    always @* begin
        next_counter = counter;
        if (wr_cnt_lo || wr_cnt_hi) begin
            if (wr_cnt_lo)
                next_counter[7:0] = wr_data[7:0];
            if (wr_cnt_hi)
                next_counter[15:8] = wr_data[15:8];
        end else if (special) begin
            next_counter = `TGO_CNT_ZERO;
        end else if (cnt_tick) begin
            next_counter = counter + 16'h0001;
        end
    end

    // hardware sets beat software writes on the flag register
    wire [2:0] flag_set;
    assign flag_set[`TGO_F_OVF]  = rollover && !special && !(wr_cnt_lo || wr_cnt_hi);
    assign flag_set[`TGO_F_GATE] = gate_fall;
    assign flag_set[`TGO_F_CC]   = do_cap || cmp_evt;

    reg [2:0] next_flags;
    always @* begin
        next_flags = peripheral_flag_reg;
        if (wr_pflag)
            next_flags = wr_data[2:0];
        next_flags = next_flags | flag_set;
    end

    // gate and edge tracking state
    always @(posedge aclk) begin
        if (!aresetn) begin
            toggle_ff         <= 1'b0;
            gate_src_q        <= 1'b0;
            gate_tog_q        <= 1'b0;
            pulse_open        <= 1'b0;
            gate_level_status <= 1'b0;
            ext_q             <= 1'b0;
            cap_q             <= 1'b0;
            match_q           <= 1'b0;
        end else begin
            gate_src_q <= gate_src;
            gate_tog_q <= gate_tog;
            ext_q      <= ext_in;
            cap_q      <= cap_in;
            match_q    <= match && cmp_mode;
            if (!gate_toggle_enable)
                toggle_ff <= 1'b0;
            else if (gate_rise)
                toggle_ff <= !toggle_ff;
            // window opens on the first edge after arming
            if (!single_pulse_enable || !gate_arm_flag || pulse_done)
                pulse_open <= 1'b0;
            else if (tog_rise)
                pulse_open <= 1'b1;
            gate_level_status <= gate_value;
        end
    end

    // software registers and counter
    always @(posedge aclk) begin
        if (!aresetn) begin
            timer_control_reg     <= 5'h00;
            gate_control_reg      <= 8'h00;
            counter               <= `TGO_CNT_ZERO;
            capcomp               <= 16'h0000;
            capcomp_ctrl          <= 3'h0;
            peripheral_flag_reg   <= 3'h0;
            peripheral_enable_reg <= 3'h0;
            irq_control_reg       <= 8'h00;
        end else begin
            counter             <= next_counter;
            peripheral_flag_reg <= next_flags;
            if (wr_tctrl)
                timer_control_reg <= wr_data[4:0];
            // arm flag: software sets it, the trailing edge clears it
            if (wr_gctrl) begin
                gate_control_reg[`TGO_G_EN:`TGO_G_SPM] <= wr_data[7:4];
                gate_control_reg[`TGO_G_ARM] <= wr_data[`TGO_G_ARM];
            end else if (pulse_done) begin
                gate_control_reg[`TGO_G_ARM] <= 1'b0;
            end
            if (do_cap)
                capcomp <= counter;
            else if (wr_ccr)
                capcomp <= wr_data[15:0];
            if (wr_ccctl)
                capcomp_ctrl <= wr_data[2:0];
            if (wr_pen)
                peripheral_enable_reg <= wr_data[2:0];
            if (wr_irqc)
                irq_control_reg <= {wr_data[7:6], 6'h00};
        end
    end

    // interrupt request, wake request and oscillator run
    wire ovf_req  = peripheral_flag_reg[`TGO_F_OVF]
                  && peripheral_enable_reg[`TGO_F_OVF] && counter_on;
    wire oth_req  = |(peripheral_flag_reg[2:1] & peripheral_enable_reg[2:1]);
    always @(posedge aclk) begin
        if (!aresetn) begin
            irq           <= 1'b0;
            wake          <= 1'b0;
            timer_osc_run <= 1'b0;
        end else begin
            irq  <= global_irq_enable && peripheral_irq_enable
                 && (ovf_req || oth_req);
            wake <= sleep_in && sleep_ok && ovf_req
                 && peripheral_irq_enable;
            timer_osc_run <= timer_osc_enable;
        end
    end

    // axi4-lite write side
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            wr_addr      <= 8'h00;
            wr_data      <= 32'h0000_0000;
            wr_strb      <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `TGO_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                wr_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held  <= 1'b1;
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `TGO_RESP_OKAY : `TGO_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read mux
    reg [31:0] rd_word;
    reg        rd_hit;
    always @* begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        case (s_axi_araddr)
            `TGO_ADDR_TCTRL:   rd_word[4:0] = timer_control_reg;
            `TGO_ADDR_GCTRL:   rd_word[7:0] = {gate_control_reg[7:3],
                                               gate_level_status, 2'b00};
            `TGO_ADDR_COUNT:   rd_word[15:0] = counter;
            `TGO_ADDR_CAPCOMP: rd_word[15:0] = capcomp;
            `TGO_ADDR_CCCTRL:  rd_word[2:0] = capcomp_ctrl;
            `TGO_ADDR_PFLAG:   rd_word[2:0] = peripheral_flag_reg;
            `TGO_ADDR_PEN:     rd_word[2:0] = peripheral_enable_reg;
            `TGO_ADDR_IRQCTL:  rd_word[7:0] = irq_control_reg;
            default:           rd_hit = 1'b0;
        endcase
    end

    // axi4-lite read side
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `TGO_RESP_OKAY;
        end else if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_hit ? `TGO_RESP_OKAY : `TGO_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// *** tb/tgo_timer_props.sv ***
// property checker on the ports of the timer block
`timescale 1ns/100ps
module tgo_timer_props (
    input wire        aclk,
    input wire        aresetn,
    input wire [7:0]  s_axi_awaddr,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [7:0]  s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire        timer_osc_run
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // both write halves taken at one edge
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // the write lands one edge after both halves are held, so the answer shows two edges on
    wr_answer_a: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
        else $error("write answer missing");
    wr_unmapped_a: assert property (s_wr_taken ##0 (s_axi_awaddr > 8'h1c)
        |-> ##2 s_axi_bresp == 2'b10)
        else $error("unmapped write not refused");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    rd_answer_a: assert property (s_rd_taken |=> s_axi_rvalid)
        else $error("read answer missing");
    rd_unmapped_a: assert property (s_rd_taken ##0 (s_axi_araddr > 8'h1c)
        |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    rd_single_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("second read accepted");
    osc_write_a: assert property ($changed(timer_osc_run) |-> s_axi_bvalid || $past(s_axi_bvalid))
        else $error("oscillator changed without write");
endmodule

// *** tb/tgo_far_end.sv ***
// far-side model: gate source, external clock and capture pins
`timescale 1ns/100ps
module tgo_far_end (
    input  wire aclk,
    output reg  gate_pin,
    output reg  ext_clk_pin,
    output reg  capture_pin
);
    // pins idle low; the external clock stands still between bursts
    initial begin
        gate_pin = 1'b0;
        ext_clk_pin = 1'b0;
        capture_pin = 1'b0;
    end
    // one gate pulse, hi cycles high then lo cycles low
    task gate_pulse(input integer hi, input integer lo);
        begin
            gate_pin <= 1'b1;
            repeat (hi) @(posedge aclk);
            gate_pin <= 1'b0;
            repeat (lo) @(posedge aclk);
        end
    endtask
    // n external clock periods of four cycles
    task ext_burst(input integer n);
        begin
            repeat (n) begin
                ext_clk_pin <= 1'b1;
                repeat (2) @(posedge aclk);
                ext_clk_pin <= 1'b0;
                repeat (2) @(posedge aclk);
            end
        end
    endtask
endmodule

// *** tb/tgo_timer_tb_top.sv ***
// testbench: bus master, scenarios and verdict for the timer block
`timescale 1ns/100ps
`include "tgo_defs.vh"
module tgo_timer_tb_top;
    reg         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, sleep, cap;
    reg  [7:0]  awaddr, araddr;
    reg  [31:0] wdata, rv, held;
    reg  [3:0]  wstrb;
    wire        awready, wready, bvalid, arready, rvalid, gate, eclk, irq, wake, osc;
    wire [1:0]  bresp, rresp;
    wire [31:0] rdata;
    integer     bad_count, n_checks, cyc;
    tgo_timer tgo_timer_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .gate_pin(gate), .ext_clk_pin(eclk), .capture_pin(cap),
        .sleep_mode(sleep), .irq(irq), .wake(wake), .timer_osc_run(osc));
    tgo_far_end tgo_far_end_inst (.aclk(aclk), .gate_pin(gate), .ext_clk_pin(eclk),
        .capture_pin());
    always #5 aclk = ~aclk;
    // hang guard
    always @(posedge aclk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            bad_count = bad_count + 1;
            print_verdict;
        end
    end
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    // write: offer both halves, release each when taken, wait for the answer
    task wr(input [7:0] a, input [31:0] d);
        begin
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            do begin
                @(posedge aclk);
                if (awready) awvalid <= 1'b0;
                if (wready) wvalid <= 1'b0;
            end while (!bvalid);
            rv = {30'h0, bresp};
            bready <= 1'b0;
        end
    endtask
    task rd(input [7:0] a);
        begin
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            do begin
                @(posedge aclk);
                if (arready) arvalid <= 1'b0;
            end while (!rvalid);
            rv = rdata;
            rready <= 1'b0;
        end
    endtask
    task sc_regs;
        begin
            rd(`TGO_ADDR_COUNT);
            chk(rv, 32'h0);
            rd(8'h40);
            chk(rv, 32'h0);
            chk({30'h0, rresp}, {30'h0, `TGO_RESP_SLVERR});
            wr(8'h40, 32'h5);
            chk(rv, 32'h2);
            wr(`TGO_ADDR_TCTRL, 32'h10);
            sleep <= 1'b1;
            repeat (8) @(posedge aclk);
            chk({31'h0, osc}, 32'h1);
            sleep <= 1'b0;
            $display("regs done");
        end
    endtask
    task sc_overflow;
        begin
            wr(`TGO_ADDR_PFLAG, 32'h0);
            wr(`TGO_ADDR_COUNT, 32'hfffd);
            wr(`TGO_ADDR_TCTRL, 32'h01);
            repeat (10) @(posedge aclk);
            rd(`TGO_ADDR_PFLAG);
            chk(rv & 32'h1, 32'h1);
            wr(`TGO_ADDR_PEN, 32'h1);
            wr(`TGO_ADDR_IRQCTL, 32'h40);
            repeat (3) @(posedge aclk);
            chk({31'h0, irq}, 32'h0);
            wr(`TGO_ADDR_IRQCTL, 32'hc0);
            repeat (3) @(posedge aclk);
            chk({31'h0, irq}, 32'h1);
            wr(`TGO_ADDR_PFLAG, 32'h0);
            repeat (3) @(posedge aclk);
            chk({31'h0, irq}, 32'h0);
            wr(`TGO_ADDR_IRQCTL, 32'h0);
            wr(`TGO_ADDR_TCTRL, 32'h0);
            $display("overflow done");
        end
    endtask
    task sc_gate_flag;
        begin
            wr(`TGO_ADDR_GCTRL, 32'h40);
            wr(`TGO_ADDR_PFLAG, 32'h0);
            tgo_far_end_inst.gate_pulse(10, 0);
            repeat (4) @(posedge aclk);
            rd(`TGO_ADDR_GCTRL);
            chk(rv & 32'h4, 32'h0);
            rd(`TGO_ADDR_PFLAG);
            chk(rv & 32'h2, 32'h2);
            $display("gate flag done");
        end
    endtask
    // counted gate window; ctl bit 5 selects toggle mode, lo is the expected minimum count
    task sc_window(input [7:0] ctl, input [31:0] lo);
        begin
            wr(`TGO_ADDR_COUNT, 32'h0);
            wr(`TGO_ADDR_GCTRL, 32'hc0);
            wr(`TGO_ADDR_GCTRL, {24'h0, ctl});
            wr(`TGO_ADDR_TCTRL, 32'h01);
            repeat (2) tgo_far_end_inst.gate_pulse(10, 10);
            rd(`TGO_ADDR_GCTRL);
            chk(rv & 32'h8, 32'h0);
            rd(`TGO_ADDR_COUNT);
            chk(rv >= lo && rv <= lo + 2, 32'h1);
            held = rv;
            tgo_far_end_inst.gate_pulse(10, 10);
            rd(`TGO_ADDR_GCTRL);
            chk(rv & 32'h8, 32'h0);
            rd(`TGO_ADDR_COUNT);
            chk(rv, held);
            // gate function off again so later scenarios count freely
            wr(`TGO_ADDR_GCTRL, 32'h40);
            wr(`TGO_ADDR_TCTRL, 32'h0);
            $display("gate window done");
        end
    endtask
    task sc_special;
        begin
            wr(`TGO_ADDR_PFLAG, 32'h0);
            wr(`TGO_ADDR_COUNT, 32'h0);
            wr(`TGO_ADDR_CAPCOMP, 32'h20);
            wr(`TGO_ADDR_CCCTRL, {30'h0, `TGO_CC_SPECIAL});
            wr(`TGO_ADDR_TCTRL, 32'h01);
            repeat (100) @(posedge aclk);
            wr(`TGO_ADDR_TCTRL, 32'h0);
            rd(`TGO_ADDR_COUNT);
            chk(rv <= 32'h20, 32'h1);
            rd(`TGO_ADDR_PFLAG);
            chk(rv & 32'h5, 32'h4);
            // capture on rising edge with the counter stopped
            wr(`TGO_ADDR_CCCTRL, 32'h5);
            cap <= 1'b1;
            repeat (4) @(posedge aclk);
            cap <= 1'b0;
            rd(`TGO_ADDR_CAPCOMP);
            held = rv;
            rd(`TGO_ADDR_COUNT);
            chk(held, rv);
            wr(`TGO_ADDR_CCCTRL, 32'h0);
            $display("special trigger done");
        end
    endtask
    task sc_sleep;
        begin
            wr(`TGO_ADDR_PFLAG, 32'h0);
            wr(`TGO_ADDR_TCTRL, 32'h01);
            sleep <= 1'b1;
            repeat (6) @(posedge aclk);
            rd(`TGO_ADDR_COUNT);
            held = rv;
            repeat (20) @(posedge aclk);
            chk(rdata, held);
            rd(`TGO_ADDR_COUNT);
            chk(rv, held);
            wr(`TGO_ADDR_TCTRL, 32'h1a);
            wr(`TGO_ADDR_COUNT, 32'hfffe);
            wr(`TGO_ADDR_PEN, 32'h1);
            wr(`TGO_ADDR_IRQCTL, 32'h40);
            wr(`TGO_ADDR_TCTRL, 32'h1b);
            tgo_far_end_inst.ext_burst(4);
            repeat (6) @(posedge aclk);
            chk({30'h0, wake, irq}, 32'h2);
            sleep <= 1'b0;
            $display("sleep done");
        end
    endtask
    task print_verdict;
        begin
            $display("checks %0d mismatches %0d", n_checks, bad_count);
            if (bad_count == 0 && n_checks > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    initial begin
        {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, sleep, cap} = 9'h0;
        {awaddr, araddr, wdata, wstrb} = 52'h0;
        wstrb = 4'hf;
        bad_count = 0;
        n_checks = 0;
        cyc = 0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        sc_regs;
        sc_overflow;
        sc_gate_flag;
        sc_window(8'hd8, 32'h9);
        sc_window(8'hf8, 32'h13);
        sc_special;
        sc_sleep;
        print_verdict;
    end
endmodule
bind tgo_timer tgo_timer_props tgo_timer_props_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .timer_osc_run(timer_osc_run));
